// ### inc/ias_cfg.svh
`ifndef IAS_CFG_SVH
`define IAS_CFG_SVH
// ****************************************
// timing constants
// ****************************************
`define IAS_CLK_HZ          125000000
`define IAS_TICK_HZ         10
`define IAS_TICK_DIV        (`IAS_CLK_HZ / `IAS_TICK_HZ)
`define IAS_PREALARM_S      60
`define IAS_EXIT_S          60
`define IAS_BYP_RESET_MIN   50
`define IAS_BYP_PRE_MIN     1
`define IAS_PREALARM_TICKS  (`IAS_PREALARM_S * `IAS_TICK_HZ)
`define IAS_EXIT_TICKS      (`IAS_EXIT_S * `IAS_TICK_HZ)
`define IAS_BYP_RESET_TICKS (`IAS_BYP_RESET_MIN * 60 * `IAS_TICK_HZ)
`define IAS_BYP_PRE_TICKS   (`IAS_BYP_PRE_MIN * 60 * `IAS_TICK_HZ)
`define IAS_FLASH_TICKS     5
`define IAS_DEBOUNCE_TICKS  1
`endif

// ### inc/ias_pkg.sv
`default_nettype none
package ias_pkg;
   // ****************************************
   // sequencer states
   // ****************************************
   typedef enum logic [2:0] {
      IAS_IDLE_ARMED,
      IAS_EXIT_WINDOW,
      IAS_DOOR_PREALARM,
      IAS_BYPASS,
      IAS_BYPASS_PREALARM,
      IAS_FULL_ALARM
   } ias_state_t;
endpackage
`default_nettype wire

// ### inc/ias_in_if.sv
`default_nettype none
// ****************************************
// cleaned inputs from the conditioner
// ****************************************
interface ias_in_if;
   logic door_open;
   logic armed;
   logic button;
   logic button_rise;
   logic tick;
   modport src (output door_open, output armed, output button, output button_rise, output tick);
   modport dst (input door_open, input armed, input button, input button_rise, input tick);
endinterface
`default_nettype wire

// ### src/ias_input_cond.sv
`include "ias_cfg.svh"
`default_nettype none
// ****************************************
// tick prescaler, synchronisers, debounce
// ****************************************
module ias_input_cond #(
   parameter int unsigned NUM_DOORS = 2,
   parameter int unsigned TICK_DIV  = `IAS_TICK_DIV
) (
   // clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 sys_rst_i,
   // raw pins
   input  wire logic [NUM_DOORS-1:0] door_open_i,
   input  wire logic                 armed_i,
   input  wire logic                 button_i,
   // cleaned outputs
   ias_in_if.src                     cln
);
   localparam int unsigned RAW_W = NUM_DOORS + 2;

   logic [31:0]      div_q;
   logic             tick_q;
   logic [RAW_W-1:0] meta_q;
   logic [RAW_W-1:0] sync_q;
   logic [RAW_W-1:0] stab_q;
   logic             btn_prev_q;

   // prescaler for the slow tick
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         div_q  <= 32'h0;
         tick_q <= 1'b0;
      end else if (div_q == TICK_DIV - 1) begin
         div_q  <= 32'h0;
         tick_q <= 1'b1; // R15
      end else begin
         div_q  <= div_q + 32'h1;
         tick_q <= 1'b0;
      end
   end

   // two-stage synchroniser
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {button_i, armed_i, door_open_i};
         sync_q <= meta_q; // R15
      end
   end

   // debounce: sample once per tick so chatter shorter than a tick is ignored
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         stab_q <= '0;
      end else if (tick_q) begin
         stab_q <= sync_q; // R15
      end
   end

   // pushbutton edge
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         btn_prev_q <= 1'b0;
      end else begin
         btn_prev_q <= stab_q[RAW_W-1];
      end
   end

   assign cln.door_open   = |stab_q[NUM_DOORS-1:0];
   assign cln.armed       = stab_q[NUM_DOORS];
   assign cln.button      = stab_q[RAW_W-1];
   assign cln.button_rise = stab_q[RAW_W-1] & ~btn_prev_q;
   assign cln.tick        = tick_q;
endmodule
`default_nettype wire

// ### src/ias_sequencer.sv
`include "ias_cfg.svh"
`default_nettype none
// Summary of operation
// R1: armed and a door opens: start 60 s pre-alarm, flash lamp.
// R2: not bypassed before pre-alarm ends: full alarm.
// R3: full alarm: lamp steady, sounder on, office flag set, recorder de-energized.
// R4: bypass ignores doors, lamp off except during bypass pre-alarm.
// R5: entering bypass starts 50 minute reset timer.
// R6: reset timer expiry flashes lamp for one-minute pre-alarm.
// R7: pushbutton during bypass pre-alarm restarts 50 minutes, lamp off.
// R8: no acknowledge within the one minute: full alarm.
// R9: arming gives 60 s exit window, closing door satisfies it.
// R10: door still open when exit window ends: full alarm.
// R11: full alarm latched until switch cycled A-B-A or B-A-B.
// R12: cycle reset silences sounder, lamp off, flag cleared, recorder energized.
// R13: after reset, re-enter sequence matching final switch position.
// R14: lamp driven regardless of panel lighting switch.
// R15: timers from prescaled tick; inputs synchronised and debounced.
module ias_sequencer #(
   parameter int unsigned NUM_DOORS       = 2,
   parameter int unsigned TICK_DIV        = `IAS_TICK_DIV,
   parameter int unsigned PREALARM_TICKS  = `IAS_PREALARM_TICKS,
   parameter int unsigned EXIT_TICKS      = `IAS_EXIT_TICKS,
   parameter int unsigned BYP_RESET_TICKS = `IAS_BYP_RESET_TICKS,
   parameter int unsigned BYP_PRE_TICKS   = `IAS_BYP_PRE_TICKS,
   parameter int unsigned FLASH_TICKS     = `IAS_FLASH_TICKS
) (
   // clock and reset
   input  wire logic                 clock_i,
   input  wire logic                 sys_rst_i,
   // field inputs
   input  wire logic [NUM_DOORS-1:0] door_open_i,
   input  wire logic                 armed_i,
   input  wire logic                 lamp_button_i,
   input  wire logic                 panel_light_on_i,
   // outputs
   output logic                      intrusion_indication_lamp_o,
   output logic                      sounder_o,
   output logic                      office_intrusion_alarm_flag_o,
   output logic                      event_recorder_energize_o,
   output logic                      full_alarm_o
);
   ias_in_if cln ();

   ias_pkg::ias_state_t state_q;
   ias_pkg::ias_state_t state_d;
   logic [31:0]         timer_q;
   logic                timer_load;
   logic [31:0]         timer_init;
   logic                timer_done;
   logic [31:0]         flash_cnt_q;
   logic                flash_q;
   logic                armed_prev_q;
   logic [1:0]          flips_q;
   logic                exit_opened_q;
   logic                lamp_d;

   // ****************************************
   // input conditioning
   // ****************************************
   ias_input_cond #(
      .NUM_DOORS (NUM_DOORS),
      .TICK_DIV  (TICK_DIV)
   ) u_cond (
      .clock_i     (clock_i),
      .sys_rst_i   (sys_rst_i),
      .door_open_i (door_open_i),
      .armed_i     (armed_i),
      .button_i    (lamp_button_i),
      .cln         (cln.src)
   );

   // ****************************************
   // state machine
   // ****************************************
   wire armed_edge = cln.armed != armed_prev_q;

   // timer expires on the tick that takes it to zero
   assign timer_done = cln.tick && (timer_q == 32'h1);

   // next-state and timer reload
   always_comb begin
      state_d    = state_q;
      timer_load = 1'b0;
      timer_init = 32'h0;
      unique case (state_q)
         ias_pkg::IAS_IDLE_ARMED: begin
            if (!cln.armed) begin
               state_d    = ias_pkg::IAS_BYPASS; // R5
               timer_load = 1'b1;
               timer_init = BYP_RESET_TICKS;
            end else if (cln.door_open) begin
               state_d    = ias_pkg::IAS_DOOR_PREALARM; // R1
               timer_load = 1'b1;
               timer_init = PREALARM_TICKS;
            end
         end
         ias_pkg::IAS_EXIT_WINDOW: begin
            if (!cln.armed) begin
               state_d    = ias_pkg::IAS_BYPASS;
               timer_load = 1'b1;
               timer_init = BYP_RESET_TICKS;
            end else if (exit_opened_q && !cln.door_open) begin
               state_d = ias_pkg::IAS_IDLE_ARMED; // R9
            end else if (timer_done) begin
               if (cln.door_open) begin
                  state_d = ias_pkg::IAS_FULL_ALARM; // R10
               end else begin
                  state_d = ias_pkg::IAS_IDLE_ARMED;
               end
            end
         end
         ias_pkg::IAS_DOOR_PREALARM: begin
            if (!cln.armed) begin
               state_d    = ias_pkg::IAS_BYPASS;
               timer_load = 1'b1;
               timer_init = BYP_RESET_TICKS;
            end else if (timer_done) begin
               state_d = ias_pkg::IAS_FULL_ALARM; // R2
            end
         end
         ias_pkg::IAS_BYPASS: begin
            // doors are not looked at here
            if (cln.armed) begin
               state_d    = ias_pkg::IAS_EXIT_WINDOW; // R9
               timer_load = 1'b1;
               timer_init = EXIT_TICKS;
            end else if (timer_done) begin
               state_d    = ias_pkg::IAS_BYPASS_PREALARM; // R6
               timer_load = 1'b1;
               timer_init = BYP_PRE_TICKS;
            end
         end
         ias_pkg::IAS_BYPASS_PREALARM: begin
            if (cln.armed) begin
               state_d    = ias_pkg::IAS_EXIT_WINDOW;
               timer_load = 1'b1;
               timer_init = EXIT_TICKS;
            end else if (cln.button_rise) begin
               state_d    = ias_pkg::IAS_BYPASS; // R7
               timer_load = 1'b1;
               timer_init = BYP_RESET_TICKS;
            end else if (timer_done) begin
               state_d = ias_pkg::IAS_FULL_ALARM; // R8
            end
         end
         ias_pkg::IAS_FULL_ALARM: begin
            // only a two-flip switch cycle leaves the latch
            if (armed_edge && flips_q == 2'd1) begin
               timer_load = 1'b1; // R11
               if (cln.armed) begin
                  state_d    = ias_pkg::IAS_EXIT_WINDOW; // R13
                  timer_init = EXIT_TICKS;
               end else begin
                  state_d    = ias_pkg::IAS_BYPASS; // R13
                  timer_init = BYP_RESET_TICKS;
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_q <= ias_pkg::IAS_BYPASS;
      end else begin
         state_q <= state_d;
      end
   end

   // timer counts down on each tick
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_q <= 32'(BYP_RESET_TICKS);
      end else if (timer_load) begin
         timer_q <= timer_init; // R15
      end else if (cln.tick && timer_q != 32'h0) begin
         timer_q <= timer_q - 32'h1;
      end
   end

   // switch position history and flip count while latched
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         armed_prev_q <= 1'b0;
         flips_q      <= 2'd0;
      end else begin
         armed_prev_q <= cln.armed;
         if (state_q != ias_pkg::IAS_FULL_ALARM) begin
            flips_q <= 2'd0;
         end else if (armed_edge && flips_q != 2'd2) begin
            flips_q <= flips_q + 2'd1; // R11
         end
      end
   end

   // exit window: remember whether the door was seen open
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         exit_opened_q <= 1'b0;
      end else if (state_q != ias_pkg::IAS_EXIT_WINDOW) begin
         exit_opened_q <= 1'b0;
      end else if (cln.door_open) begin
         exit_opened_q <= 1'b1; // R9
      end
   end

   // ****************************************
   // flash cadence and outputs
   // ****************************************
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         flash_cnt_q <= 32'h0;
         flash_q     <= 1'b0;
      end else if (cln.tick) begin
         if (flash_cnt_q == FLASH_TICKS - 1) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= ~flash_q; // R15
         end else begin
            flash_cnt_q <= flash_cnt_q + 32'h1;
         end
      end
   end

   // lamp ignores panel lighting switch
   always_comb begin
      unique case (state_d)
         ias_pkg::IAS_DOOR_PREALARM:   lamp_d = flash_q; // R1
         ias_pkg::IAS_BYPASS_PREALARM: lamp_d = flash_q; // R6
         ias_pkg::IAS_FULL_ALARM:      lamp_d = 1'b1;    // R3
         default:                      lamp_d = 1'b0;    // R4 R12 R14
      endcase
   end

   // registered outputs
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         intrusion_indication_lamp_o   <= 1'b0;
         sounder_o                     <= 1'b0;
         office_intrusion_alarm_flag_o <= 1'b0;
         event_recorder_energize_o     <= 1'b1;
         full_alarm_o                  <= 1'b0;
      end else begin
         intrusion_indication_lamp_o   <= lamp_d; // R14
         sounder_o                     <= state_d == ias_pkg::IAS_FULL_ALARM; // R3 R12
         office_intrusion_alarm_flag_o <= state_d == ias_pkg::IAS_FULL_ALARM; // R3 R12
         event_recorder_energize_o     <= state_d != ias_pkg::IAS_FULL_ALARM; // R3 R12
         full_alarm_o                  <= state_d == ias_pkg::IAS_FULL_ALARM;
      end
   end

   // panel lighting input is accepted but never gates the lamp
   wire unused_ok = panel_light_on_i;
endmodule
`default_nettype wire

// ### tb/ias_seq_checker.sv
`default_nettype none
// ****************************************
// sequencer port checks
// ****************************************
module ias_seq_checker #(
   parameter int unsigned TICK_DIV    = 4,
   parameter int unsigned EXIT_TICKS  = 20,
   parameter int unsigned FLASH_TICKS = 2
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // switch
   input wire logic armed_i,
   // outputs watched
   input wire logic intrusion_indication_lamp_o,
   input wire logic sounder_o,
   input wire logic office_intrusion_alarm_flag_o,
   input wire logic event_recorder_energize_o,
   input wire logic full_alarm_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        arm_q;
   logic [15:0] age_q;
   logic [15:0] run_q;
   default clocking @(posedge clock_i); endclocking
   default disable iff (sys_rst_i);
   // cycles since the switch moved, and length of a lamp-on run outside full alarm
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         arm_q <= 1'b0;
         age_q <= 16'h0;
         run_q <= 16'h0;
      end else begin
         arm_q <= armed_i;
         age_q <= (armed_i != arm_q) ? 16'h0 : ((age_q == 16'hFFFF) ? age_q : age_q + 16'h1);
         run_q <= (intrusion_indication_lamp_o && !full_alarm_o) ? run_q + 16'h1 : 16'h0;
      end
   end
   AST_FULL_LAMP: assert property (full_alarm_o |-> intrusion_indication_lamp_o)
      else $error("lamp not steady in full alarm");
   AST_FULL_SOUND: assert property (sounder_o == full_alarm_o)
      else $error("sounder disagrees with full alarm");
   AST_FULL_FLAG: assert property (office_intrusion_alarm_flag_o == full_alarm_o)
      else $error("office flag disagrees with full alarm");
   AST_FULL_REC: assert property (event_recorder_energize_o != full_alarm_o)
      else $error("recorder output wrong for alarm state");
   AST_LATCH: assert property (full_alarm_o && age_q > TICK_DIV + 8 |=> full_alarm_o)
      else $error("full alarm cleared without switch cycle");
   AST_FLASH: assert property (run_q <= FLASH_TICKS * TICK_DIV + 1)
      else $error("lamp lit too long while flashing");
   AST_EARLY: assert property ($rose(full_alarm_o) |-> age_q >= (EXIT_TICKS - 1) * TICK_DIV)
      else $error("full alarm too soon after switch move");
   AST_CLEAR: assert property ($fell(full_alarm_o) |-> !intrusion_indication_lamp_o)
      else $error("lamp still lit after alarm reset");
endmodule
bind ias_sequencer ias_seq_checker #(
   .TICK_DIV   (TICK_DIV),
   .EXIT_TICKS (EXIT_TICKS),
   .FLASH_TICKS(FLASH_TICKS)
) u_checker (
   .clock_i                      (clock_i),
   .sys_rst_i                    (sys_rst_i),
   .armed_i                      (armed_i),
   .intrusion_indication_lamp_o  (intrusion_indication_lamp_o),
   .sounder_o                    (sounder_o),
   .office_intrusion_alarm_flag_o(office_intrusion_alarm_flag_o),
   .event_recorder_energize_o    (event_recorder_energize_o),
   .full_alarm_o                 (full_alarm_o)
);
`default_nettype wire

// ### tb/ias_field_model.sv
`default_nettype none
// ****************************************
// doors, switch and pushbutton contacts
// ****************************************
module ias_field_model (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       sys_rst_i,
   // requests from the bench
   input  wire logic [1:0] door_req_i,
   input  wire logic       arm_req_i,
   input  wire logic       press_req_i,
   // contacts toward the sequencer
   output logic [1:0]      door_open_o,
   output logic            armed_o,
   output logic            button_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // contacts follow a request one clock late, like slow relays
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         door_open_o <= 2'h0;
         armed_o     <= 1'b0;
         button_o    <= 1'b0;
      end else begin
         door_open_o <= door_req_i;
         armed_o     <= arm_req_i;
         button_o    <= press_req_i;
      end
   end
endmodule
`default_nettype wire

// ### tb/test_intrusion_alarm_sequencer.sv
`default_nettype none
module test_intrusion_alarm_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int T   = 4;
   localparam int PRE = 20;
   localparam int EXT = 20;
   localparam int BRT = 50;
   localparam int BPT = 20;
   localparam int FLT = 2;
   logic       clock_i   = 1'b0;
   logic       sys_rst_i = 1'b1;
   logic [1:0] door_req  = 2'h0;
   logic       arm_req   = 1'b0;
   logic       press_req = 1'b0;
   logic       panel     = 1'b0;
   logic       seen_lamp;
   wire  [1:0] door;
   wire        armed, button, lamp, sounder, flag, rec, full;
   int         err_count = 0;
   int         n_checks  = 0;
   int         cyc       = 0;
   int         seed      = 32'hEA43;
   int         n;
   ias_field_model u_field (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .door_req_i(door_req), .arm_req_i(arm_req),
      .press_req_i(press_req), .door_open_o(door), .armed_o(armed), .button_o(button));
   ias_sequencer #(.NUM_DOORS(2), .TICK_DIV(T), .PREALARM_TICKS(PRE), .EXIT_TICKS(EXT), .BYP_RESET_TICKS(BRT),
      .BYP_PRE_TICKS(BPT), .FLASH_TICKS(FLT)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .door_open_i(door),
      .armed_i(armed), .lamp_button_i(button), .panel_light_on_i(panel), .intrusion_indication_lamp_o(lamp),
      .sounder_o(sounder), .office_intrusion_alarm_flag_o(flag), .event_recorder_energize_o(rec),
      .full_alarm_o(full));
   // clock, hang guard and panel lighting noise
   always #4 clock_i = ~clock_i;
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      panel <= 1'($random(seed));
      if (cyc == 20000) begin
         err_count++;
         finish_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // expected delay in clocks for a count of ticks, with sync and tick slack
   function automatic logic in_win(input int k, input int ticks);
      return k >= (ticks - 1) * T && k <= (ticks + 2) * T + 8;
   endfunction
   task automatic wait_alarm(output int k);
      k = 0;
      seen_lamp = 1'b0;
      while (full !== 1'b1 && k < 600) begin
         @(posedge clock_i);
         #1;
         k++;
         seen_lamp = seen_lamp | lamp;
      end
   endtask
   task automatic sw(input logic v);
      @(posedge clock_i);
      arm_req <= v;
      repeat (4 * T) @(posedge clock_i);
      #1;
   endtask
   // random door traffic while the lamp must stay dark
   task automatic bypass_dark(input int k);
      logic lit;
      lit = 1'b0;
      repeat (k) begin
         @(posedge clock_i);
         door_req <= 2'($random(seed));
         #1;
         lit = lit | lamp | full;
      end
      @(posedge clock_i);
      door_req <= 2'h0;
      check(lit, 1'b0);
   endtask
   // ****************************************
   // reference model of the rules, one step per tick of its own
   // ****************************************
   // model states: 0 armed idle, 1 exit window, 2 door pre-alarm, 3 bypass, 4 bypass pre-alarm, 5 full alarm
   int         m_st    = 3;
   int         m_nx;
   int         m_ld;
   int         m_tmr   = BRT;
   int         m_flip  = 0;
   int         m_age   = 0;
   int         m_quiet = 0;
   int         m_div   = 0;
   logic       m_open  = 1'b0;
   logic       m_arm   = 1'b0;
   logic       m_btn   = 1'b0;
   logic [3:0] m_pins  = 4'h0;
   // contacts looked at on the falling edge, where the design's outputs have settled
   always @(negedge clock_i) begin
      if (!sys_rst_i) begin
         m_quiet = (m_pins == {armed, button, door}) ? m_quiet + 1 : 0;
         m_pins  = {armed, button, door};
         m_div   = (m_div == T - 1) ? 0 : m_div + 1;
         if (m_div == 0) begin
            m_nx = m_st;
            m_ld = 0;
            case (m_st)
               0: begin
                  if (!armed) begin
                     m_nx = 3;
                     m_ld = BRT;
                  end else if (door != 2'h0) begin
                     m_nx = 2;
                     m_ld = PRE;
                  end
               end
               1: begin
                  if (!armed) begin
                     m_nx = 3;
                     m_ld = BRT;
                  end else if (m_open && door == 2'h0) begin
                     m_nx = 0;
                  end else if (m_tmr == 1) begin
                     m_nx = (door != 2'h0) ? 5 : 0;
                  end
               end
               2: begin
                  if (!armed) begin
                     m_nx = 3;
                     m_ld = BRT;
                  end else if (m_tmr == 1) begin
                     m_nx = 5;
                  end
               end
               3, 4: begin
                  if (armed) begin
                     m_nx = 1;
                     m_ld = EXT;
                  end else if (m_st == 4 && button && !m_btn) begin
                     m_nx = 3;
                     m_ld = BRT;
                  end else if (m_tmr == 1) begin
                     m_nx = (m_st == 3) ? 4 : 5;
                     m_ld = (m_st == 3) ? BPT : 0;
                  end
               end
               default: begin
                  if (armed != m_arm) begin
                     m_flip++;
                  end
                  if (m_flip == 2) begin
                     m_nx = armed ? 1 : 3;
                     m_ld = armed ? EXT : BRT;
                  end
               end
            endcase
            m_open = (m_st == 1 && m_nx == 1) ? (m_open || door != 2'h0) : 1'b0;
            m_flip = (m_nx == 5) ? m_flip : 0;
            m_age  = (m_nx == m_st) ? m_age + 1 : 0;
            m_tmr  = (m_ld > 0) ? m_ld : ((m_tmr > 0) ? m_tmr - 1 : 0);
            m_st   = m_nx;
            m_arm  = armed;
            m_btn  = button;
            // compare only where both sides have settled: no recent move, no timer near expiry
            if (m_age >= 3 && m_quiet >= 3 * T && (m_st == 0 || m_st == 5 || m_tmr > 3)) begin
               check({sounder, flag, rec, full}, (m_st == 5) ? 4'hD : 4'h2);
               if (m_st != 2 && m_st != 4) begin
                  check(lamp, m_st == 5);
               end
            end
         end
      end
   end
   initial begin
      repeat (10) @(posedge clock_i);
      sys_rst_i <= 1'b0;
      #1;
      check({lamp, sounder, flag, rec, full}, 5'h02);
      bypass_dark(150);
      n = 151;
      while (lamp !== 1'b1 && n < 400) begin
         @(posedge clock_i);
         #1;
         n++;
      end
      check(in_win(n, BRT), 1'b1);
      @(posedge clock_i);
      press_req <= 1'b1;
      repeat (3 * T) @(posedge clock_i);
      press_req <= 1'b0;
      bypass_dark(150);
      wait_alarm(n);
      check(in_win(n + 3 * T + 151, BRT + BPT), 1'b1);
      check({lamp, sounder, flag, rec, full}, 5'h1D);
      @(posedge clock_i);
      press_req <= 1'b1;
      door_req <= 2'h3;
      repeat (6 * T) @(posedge clock_i);
      press_req <= 1'b0;
      door_req <= 2'h0;
      sw(1'b1);
      check(full, 1'b1);
      sw(1'b0);
      check({lamp, sounder, flag, rec, full}, 5'h02);
      bypass_dark(150);
      sw(1'b1);
      @(posedge clock_i);
      door_req <= 2'h1;
      repeat (4 * T) @(posedge clock_i);
      door_req <= 2'h0;
      repeat (30 * T) @(posedge clock_i);
      #1;
      check(full, 1'b0);
      @(posedge clock_i);
      door_req <= 2'h2;
      wait_alarm(n);
      check(in_win(n, PRE), 1'b1);
      check(seen_lamp, 1'b1);
      sw(1'b0);
      check(full, 1'b1);
      sw(1'b1);
      check(full, 1'b0);
      wait_alarm(n);
      check(in_win(n + 4 * T, EXT), 1'b1);
      door_req <= 2'h0;
      finish_test();
   end
endmodule
`default_nettype wire
